// File: gp_timer_capture_pwm.sv
// Notes on behaviour
// R1 - pin level held two clocks after edges
// R2 - no prescaler in capture or pwm modes
// R3 - count mode counts chosen edge kinds down
// R4 - each event decrements until match value
// R5 - at match: flag, reload, clear enable
// R6 - time mode free-runs down, one edge kind
// R7 - selected edge copies count, sets flag
// R8 - time mode keeps counting, reloads at zero
// R9 - captured value held until next edge
// R10 - pwm selected by alternate, capture, mode bits
// R11 - pwm counts down, reloads, no flags
// R12 - pwm high at start, low at match
// R13 - 32-bit one-shot/periodic setup sequence
// R14 - timeout flag cleared by writing one
// R15 - rtc setup sequence with pin clock
// R16 - rtc wraps to zero at match
// R17 - 16-bit one-shot/periodic setup sequence
// R18 - one-shot stops, periodic keeps counting
// R19 - configuration changed only while disabled
// R20 - timer runs only when clock gate set
// R21 - pin synchronised, edges found by comparison
`timescale 1ns/1ps
module gp_timer_capture_pwm
   import gp_timer_pkg::*;
#(
   parameter int unsigned RTC_DIV = RTC_DIV_DEFAULT
) (
   input wire logic clock_in,
   input wire logic sys_rst_in,
   input wire logic [ADDR_W-1:0] awaddr_in,
   input wire logic awvalid_in,
   output logic awready_out,
   input wire logic [31:0] wdata_in,
   input wire logic [3:0] wstrb_in,
   input wire logic wvalid_in,
   output logic wready_out,
   output logic [1:0] bresp_out,
   output logic bvalid_out,
   input wire logic bready_in,
   input wire logic [ADDR_W-1:0] araddr_in,
   input wire logic arvalid_in,
   output logic arready_out,
   output logic [31:0] rdata_out,
   output logic [1:0] rresp_out,
   output logic rvalid_out,
   input wire logic rready_in,
   input wire logic stall_in,
   input wire logic ccp_in,
   output logic ccp_out,
   output logic ccp_oe_out
);

   generate
      if (RTC_DIV < 2 || RTC_DIV > 65536) begin : g_bad_div
         $error("RTC_DIV must lie in 2..65536");
      end
   endgenerate

   localparam logic [15:0] RTC_DIV_LAST = 16'(RTC_DIV - 1);

   typedef struct packed {
      logic awready;
      logic aw_held;
      logic [ADDR_W-1:0] aw_addr;
      logic wready;
      logic w_held;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [2:0] cfg;
      logic [3:0] mode;
      logic [6:0] ctl;
      logic [3:0] imr;
      logic [3:0] ris;
      logic [31:0] ilr;
      logic [31:0] match;
      logic [7:0] pre;
      logic [7:0] pre_cnt;
      logic [31:0] cnt;
      logic [15:0] cap;
      logic [15:0] rtc_div;
      logic pwm_level;
      logic gate;
      logic capture_compare_pin;
      logic ccp_oe;
   } timer_state_t;

   timer_state_t st;
   timer_state_t next_st;

   logic pin_rise;
   logic pin_fall;

   pin_edge_sync u_sync (
      .clock_in(clock_in),
      .sys_rst_in(sys_rst_in),
      .pin_in(ccp_in),
      .rise_out(pin_rise),
      .fall_out(pin_fall)
   );

   // ------------------------------------------------------------
   // register helpers
   // ------------------------------------------------------------
   function automatic logic [31:0] merge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [3:0] strb);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic mapped(input logic [ADDR_W-1:0] a);
      return a == OFF_CFG || a == OFF_MODE || a == OFF_CTL ||
         a == OFF_IMR || a == OFF_RIS || a == OFF_MIS ||
         a == OFF_ICR || a == OFF_ILR || a == OFF_MATCH ||
         a == OFF_PRE || a == OFF_VAL || a == OFF_GATE;
   endfunction

   function automatic logic [31:0] reg_value(input logic [ADDR_W-1:0] a,
                                             input timer_state_t s);
      logic [31:0] v;
      v = 32'h00000000;
      case (a)
         OFF_CFG: v = {29'h0, s.cfg};
         OFF_MODE: v = {28'h0, s.mode};
         OFF_CTL: v = {25'h0, s.ctl};
         OFF_IMR: v = {28'h0, s.imr};
         OFF_RIS: v = {28'h0, s.ris};
         OFF_MIS: v = {28'h0, s.ris & s.imr};
         OFF_ILR: v = s.ilr;
         OFF_MATCH: v = s.match;
         OFF_PRE: v = {24'h0, s.pre};
         OFF_VAL: begin
            // edge time mode shows the captured count
            if (s.cfg == CFG_16 && s.mode[1:0] == MR_CAPTURE &&
                s.mode[MODE_CMR_BIT]) begin
               v = {16'h0, s.cap}; // R9
            end else begin
               v = s.cnt;
            end
         end
         OFF_GATE: v = {31'h0, s.gate};
         default: v = 32'h00000000;
      endcase
      return v;
   endfunction

   // ------------------------------------------------------------
   // decoded mode and working values
   // ------------------------------------------------------------
   logic is16;
   logic is_rtc;
   logic is_cap;
   logic is_pwm;
   logic is_ts;
   logic run;
   logic frozen;
   logic cnt_evt;
   logic time_evt;
   logic tick;
   logic do_write;
   logic [ADDR_W-1:0] wa;
   logic [ADDR_W-1:0] ra;
   logic [31:0] wd;
   logic [31:0] top;
   logic [31:0] mtop;
   logic [15:0] dec16;
   logic [3:0] sets;
   logic [1:0] evt_sel;

   always_comb begin
      next_st = st;
      sets = 4'h0;
      is16 = (st.cfg == CFG_16);
      is_rtc = (st.cfg == CFG_RTC);
      is_cap = is16 && st.mode[1:0] == MR_CAPTURE &&
         !st.mode[MODE_AMS_BIT];
      is_pwm = is16 && st.mode[MODE_AMS_BIT] && // R10
         !st.mode[MODE_CMR_BIT] && st.mode[1:0] == MR_PERIODIC;
      is_ts = (st.cfg == CFG_32 || is16) && !st.mode[MODE_AMS_BIT] &&
         (st.mode[1:0] == MR_ONESHOT || st.mode[1:0] == MR_PERIODIC);
      run = st.ctl[CTL_EN_BIT] && st.gate; // R20
      frozen = st.ctl[CTL_STALL_BIT] && stall_in &&
         !(is_rtc && st.ctl[CTL_STALL_OVERRIDE_BIT_BIT]);
      evt_sel = st.ctl[CTL_EVT_LSB +: 2];
      cnt_evt = (evt_sel == EVT_RISE && pin_rise) || // R3
         (evt_sel == EVT_FALL && pin_fall) ||
         (evt_sel == EVT_BOTH && (pin_rise || pin_fall));
      time_evt = (evt_sel == EVT_FALL) ? pin_fall : pin_rise; // R6
      top = is16 ? {16'h0, st.ilr[15:0]} : st.ilr;
      mtop = is16 ? {16'h0, st.match[15:0]} : st.match;
      dec16 = st.cnt[15:0] - 16'h0001;
      tick = !is16 || st.pre_cnt == 8'h00;
      wa = {st.aw_addr[ADDR_W-1:2], 2'h0};
      ra = {araddr_in[ADDR_W-1:2], 2'h0};
      wd = merge(reg_value(wa, st), st.w_data, st.w_strb);
      do_write = st.aw_held && st.w_held && !st.bvalid;

      // ---------------------------------------------------------
      // counting engine
      // ---------------------------------------------------------
      if (run && !frozen) begin
         if (is_rtc) begin
            if (pin_rise) begin
               if (st.rtc_div == RTC_DIV_LAST) begin
                  next_st.rtc_div = 16'h0000;
                  if (st.cnt == st.match) begin
                     next_st.cnt = 32'h00000000; // R16
                     sets[IRQ_RTC_BIT] = 1'b1;
                  end else begin
                     next_st.cnt = st.cnt + 32'h00000001;
                  end
               end else begin
                  next_st.rtc_div = st.rtc_div + 16'h0001;
               end
            end
         end else if (is_cap && !st.mode[MODE_CMR_BIT]) begin
            // edge count: counter moves only on events, no prescale
            if (cnt_evt) begin // R2
               if (dec16 == mtop[15:0]) begin // R4
                  sets[IRQ_CM_BIT] = 1'b1; // R5
                  next_st.cnt = top;
                  next_st.ctl[CTL_EN_BIT] = 1'b0;
               end else begin
                  next_st.cnt = {16'h0, dec16}; // R4
               end
            end
         end else if (is_cap) begin
            if (st.cnt[15:0] == 16'h0000) begin
               next_st.cnt = top; // R8
            end else begin
               next_st.cnt = {16'h0, dec16}; // R2
            end
            if (time_evt) begin
               next_st.cap = st.cnt[15:0]; // R7
               sets[IRQ_CE_BIT] = 1'b1; // R7
            end
         end else if (is_pwm) begin
            // no status is raised in this mode
            if (st.cnt[15:0] == 16'h0000) begin
               next_st.cnt = top; // R11
            end else begin
               next_st.cnt = {16'h0, dec16}; // R11
            end
            if (st.cnt == top) begin
               next_st.pwm_level = 1'b1; // R12
            end else if (st.cnt == mtop) begin
               next_st.pwm_level = 1'b0; // R12
            end
         end else if (is_ts) begin
            if (is16) begin
               if (st.pre_cnt == 8'h00) begin
                  next_st.pre_cnt = st.pre;
               end else begin
                  next_st.pre_cnt = st.pre_cnt - 8'h01;
               end
            end
            if (tick) begin
               if (st.cnt == 32'h00000000) begin
                  next_st.cnt = top;
                  sets[IRQ_TO_BIT] = 1'b1;
                  if (st.mode[1:0] == MR_ONESHOT) begin
                     next_st.ctl[CTL_EN_BIT] = 1'b0; // R18
                  end
               end else begin
                  next_st.cnt = st.cnt - 32'h00000001; // R18
               end
            end
         end
      end
      next_st.ccp_oe = is_pwm && st.gate;
      next_st.capture_compare_pin = is_pwm && (st.pwm_level ^ st.ctl[CTL_PWML_BIT]); // R12

      // ---------------------------------------------------------
      // write channel
      // ---------------------------------------------------------
      if (st.bvalid && bready_in) begin
         next_st.bvalid = 1'b0;
      end
      if (awvalid_in && st.awready) begin
         next_st.aw_held = 1'b1;
         next_st.aw_addr = awaddr_in;
      end
      if (wvalid_in && st.wready) begin
         next_st.w_held = 1'b1;
         next_st.w_data = wdata_in;
         next_st.w_strb = wstrb_in;
      end
      if (do_write) begin
         next_st.aw_held = 1'b0;
         next_st.w_held = 1'b0;
         next_st.bvalid = 1'b1;
         next_st.bresp = mapped(wa) ? RESP_OKAY : RESP_SLVERR;
         case (wa)
            OFF_CFG: begin
               next_st.cfg = wd[2:0];
               if (wd[2:0] == CFG_RTC) begin
                  next_st.cnt = RTC_START;
                  next_st.rtc_div = 16'h0000;
               end
            end
            OFF_MODE: next_st.mode = wd[3:0];
            OFF_CTL: next_st.ctl = wd[6:0];
            OFF_IMR: next_st.imr = wd[3:0];
            OFF_ICR: next_st.ris = st.ris & ~wd[3:0]; // R14
            OFF_ILR: begin
               next_st.ilr = wd;
               if (!is_rtc) begin
                  next_st.cnt = is16 ? {16'h0, wd[15:0]} : wd;
                  next_st.pre_cnt = st.pre;
               end
            end
            OFF_MATCH: next_st.match = wd;
            OFF_PRE: next_st.pre = wd[7:0];
            OFF_GATE: next_st.gate = wd[GATE_BIT];
            default: next_st.bresp = next_st.bresp;
         endcase
      end
      // a hardware event in the clearing cycle still lands
      next_st.ris = next_st.ris | sets; // R14

      // ---------------------------------------------------------
      // read channel
      // ---------------------------------------------------------
      if (st.rvalid && rready_in) begin
         next_st.rvalid = 1'b0;
      end
      if (arvalid_in && st.arready) begin
         next_st.rvalid = 1'b1;
         next_st.rdata = reg_value(ra, st);
         next_st.rresp = mapped(ra) ? RESP_OKAY : RESP_SLVERR;
      end
      next_st.awready = !next_st.aw_held;
      next_st.wready = !next_st.w_held;
      next_st.arready = !next_st.rvalid;
   end

   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         st <= '0;
         st.awready <= 1'b1;
         st.wready <= 1'b1;
         st.arready <= 1'b1;
         st.ilr <= ILR_RESET;
         st.match <= MATCH_RESET;
         st.cnt <= CNT_RESET;
      end else begin
         st <= next_st;
      end
   end

   assign awready_out = st.awready;
   assign wready_out = st.wready;
   assign bresp_out = st.bresp;
   assign bvalid_out = st.bvalid;
   assign arready_out = st.arready;
   assign rdata_out = st.rdata;
   assign rresp_out = st.rresp;
   assign rvalid_out = st.rvalid;
   assign ccp_out = st.capture_compare_pin;
   assign ccp_oe_out = st.ccp_oe;

endmodule

// File: gp_timer_pkg.sv
package gp_timer_pkg;

   // ------------------------------------------------------------
   // bus geometry and register offsets
   // ------------------------------------------------------------
   localparam int ADDR_W = 12;
   localparam logic [11:0] OFF_CFG = 12'h000;
   localparam logic [11:0] OFF_MODE = 12'h004;
   localparam logic [11:0] OFF_CTL = 12'h00C;
   localparam logic [11:0] OFF_IMR = 12'h018;
   localparam logic [11:0] OFF_RIS = 12'h01C;
   localparam logic [11:0] OFF_MIS = 12'h020;
   localparam logic [11:0] OFF_ICR = 12'h024;
   localparam logic [11:0] OFF_ILR = 12'h028;
   localparam logic [11:0] OFF_MATCH = 12'h030;
   localparam logic [11:0] OFF_PRE = 12'h038;
   localparam logic [11:0] OFF_VAL = 12'h048;
   localparam logic [11:0] OFF_GATE = 12'h100;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ------------------------------------------------------------
   // configuration encodings
   // ------------------------------------------------------------
   localparam logic [2:0] CFG_32 = 3'h0;
   localparam logic [2:0] CFG_RTC = 3'h1;
   localparam logic [2:0] CFG_16 = 3'h4;

   localparam logic [1:0] MR_ONESHOT = 2'h1;
   localparam logic [1:0] MR_PERIODIC = 2'h2;
   localparam logic [1:0] MR_CAPTURE = 2'h3;

   localparam logic [1:0] EVT_RISE = 2'h0;
   localparam logic [1:0] EVT_FALL = 2'h1;
   localparam logic [1:0] EVT_BOTH = 2'h3;

   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int MODE_MR_LSB = 0;
   localparam int MODE_CMR_BIT = 2;
   localparam int MODE_AMS_BIT = 3;
   localparam int CTL_EN_BIT = 0;
   localparam int CTL_STALL_BIT = 1;
   localparam int CTL_EVT_LSB = 2;
   localparam int CTL_STALL_OVERRIDE_BIT_BIT = 4;
   localparam int CTL_PWML_BIT = 6;
   localparam int IRQ_TO_BIT = 0;
   localparam int IRQ_CM_BIT = 1;
   localparam int IRQ_CE_BIT = 2;
   localparam int IRQ_RTC_BIT = 3;
   localparam int GATE_BIT = 0;

   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   localparam logic [31:0] ILR_RESET = 32'h0000FFFF;
   localparam logic [31:0] MATCH_RESET = 32'h0000FFFF;
   localparam logic [31:0] CNT_RESET = 32'h0000FFFF;
   localparam logic [31:0] RTC_START = 32'h00000001;
   localparam int RTC_DIV_DEFAULT = 32768;

endpackage

// File: pin_edge_sync.sv
`timescale 1ns/1ps
module pin_edge_sync (
   input wire logic clock_in,
   input wire logic sys_rst_in,
   input wire logic pin_in,
   output logic rise_out,
   output logic fall_out
);

   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic level;
      logic rise;
      logic fall;
   } sync_state_t;

   sync_state_t st;
   sync_state_t next_st;

   // ------------------------------------------------------------
   // three-stage synchroniser and edge qualifier
   // ------------------------------------------------------------
   always_comb begin
      next_st = st;
      next_st.s1 = pin_in;
      next_st.s2 = st.s1;
      next_st.s3 = st.s2;
      next_st.rise = 1'b0;
      next_st.fall = 1'b0;
      // a level counts once the last two stages agree
      if ((st.s2 == st.s3) && (st.s3 != st.level)) begin // R21
         next_st.level = st.s3;
         next_st.rise = st.s3;
         next_st.fall = ~st.s3;
      end
   end

   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         // pin idles high: a high reset level avoids a false rise
         st <= '{s1: 1'b1, s2: 1'b1, s3: 1'b1, level: 1'b1,
                 default: 1'b0};
      end else begin
         st <= next_st;
      end
   end

   assign rise_out = st.rise;
   assign fall_out = st.fall;

endmodule

// File: gp_timer_props.sv
`timescale 1ns/1ps
module gp_timer_props
   import gp_timer_pkg::*;
(
   input wire logic clock_in,
   input wire logic sys_rst_in,
   input wire logic awvalid_in,
   input wire logic awready_out,
   input wire logic wvalid_in,
   input wire logic wready_out,
   input wire logic bvalid_out,
   input wire logic [1:0] bresp_out,
   input wire logic bready_in,
   input wire logic [ADDR_W-1:0] araddr_in,
   input wire logic arvalid_in,
   input wire logic arready_out,
   input wire logic [31:0] rdata_out,
   input wire logic [1:0] rresp_out,
   input wire logic rvalid_out,
   input wire logic rready_in,
   input wire logic ccp_out,
   input wire logic ccp_oe_out
);
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (sys_rst_in);
   wire wr_take = awvalid_in && awready_out && wvalid_in && wready_out;
   wire rd_take = arvalid_in && arready_out;
   // ---------------------------------------------
   // bus and pin relations
   // ---------------------------------------------
   write_answer_a: assert property (wr_take |-> ##2 bvalid_out)
      else $error("write response late");
   write_close_a: assert property (wr_take |=> !awready_out && !wready_out)
      else $error("write channels not closed");
   bresp_hold_a: assert property (bvalid_out && !bready_in |=>
      bvalid_out && $stable(bresp_out)) else $error("bresp dropped");
   read_answer_a: assert property (rd_take |=> rvalid_out)
      else $error("read response late");
   rdata_hold_a: assert property (rvalid_out && !rready_in |=>
      rvalid_out && $stable(rdata_out)) else $error("rdata dropped");
   arready_gate_a: assert property (arready_out == !rvalid_out)
      else $error("arready not inverse of rvalid");
   unmapped_read_a: assert property (rd_take && araddr_in > 12'h103 |=>
      rresp_out == RESP_SLVERR && rdata_out == 32'h0)
      else $error("unmapped read not refused");
   idle_pin_a: assert property ($fell(sys_rst_in) |->
      (!ccp_oe_out && !ccp_out) [*3]) else $error("pin driven after reset");
   cover property (wr_take);
   cover property (rd_take);
   cover property ($rose(ccp_out));
endmodule

// File: pin_partner.sv
`timescale 1ns/1ps
module pin_partner (
   input wire logic clock_in,
   input wire logic pin_in,
   output logic drive_out
);
   initial drive_out = 1'b1;
   task automatic toggle(input int n);
      repeat (n) begin
         @(posedge clock_in);
         drive_out <= ~drive_out;
         repeat (2) @(posedge clock_in);
      end
   endtask
   // two rising edges d clocks apart, one falling edge between
   task automatic rises(input int d);
      @(posedge clock_in);
      drive_out <= 1'b1;
      repeat (60) @(posedge clock_in);
      drive_out <= 1'b0;
      repeat (d - 60) @(posedge clock_in);
      drive_out <= 1'b1;
   endtask
   task automatic measure(input int n, output int hi);
      hi = 0;
      repeat (n) begin
         // sample mid-cycle, away from the launching edge
         @(negedge clock_in);
         if (pin_in === 1'b1) hi++;
      end
   endtask
endmodule

// File: gp_timer_capture_pwm_bench.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin err_count++; \
   $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module gp_timer_capture_pwm_bench
   import gp_timer_pkg::*;
;
   logic clock_in = 0, sys_rst_in = 1, stall_in = 0;
   logic awvalid_in = 0, wvalid_in = 0, bready_in = 0;
   logic arvalid_in = 0, rready_in = 0;
   logic [11:0] awaddr_in = 0, araddr_in = 0;
   logic [31:0] wdata_in = 0, rdata_out, d, c1;
   logic [3:0] wstrb_in = 4'hF;
   logic [1:0] bresp_out, rresp_out, rsp;
   logic awready_out, wready_out, bvalid_out, arready_out, rvalid_out;
   logic ccp_out, ccp_oe_out, pin_drive, pin_level;
   logic [15:0] rnd = 16'h0029;
   logic [1:0] evq[$] = '{EVT_RISE, EVT_FALL, EVT_BOTH};
   int err_count = 0, checked = 0, hi, k;
   assign pin_level = ccp_oe_out ? ccp_out : pin_drive;
   always #2 clock_in = ~clock_in;
   gp_timer_capture_pwm #(.RTC_DIV(4)) i_gp_timer_capture_pwm (
      .clock_in(clock_in), .sys_rst_in(sys_rst_in),
      .awaddr_in(awaddr_in), .awvalid_in(awvalid_in),
      .awready_out(awready_out), .wdata_in(wdata_in), .wstrb_in(wstrb_in),
      .wvalid_in(wvalid_in), .wready_out(wready_out),
      .bresp_out(bresp_out), .bvalid_out(bvalid_out),
      .bready_in(bready_in), .araddr_in(araddr_in),
      .arvalid_in(arvalid_in), .arready_out(arready_out),
      .rdata_out(rdata_out), .rresp_out(rresp_out),
      .rvalid_out(rvalid_out), .rready_in(rready_in),
      .stall_in(stall_in), .ccp_in(pin_level), .ccp_out(ccp_out),
      .ccp_oe_out(ccp_oe_out));
   pin_partner i_pin_partner (.clock_in(clock_in), .pin_in(pin_level),
      .drive_out(pin_drive));
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   function automatic int wrapc(int c, int dd, int p);
      return ((c - dd) % p + p) % p;
   endfunction
   // ---------------------------------------------
   // bus tasks
   // ---------------------------------------------
   task automatic wr(input logic [11:0] a, input logic [31:0] v);
      logic pa = 1'b1;
      logic pw = 1'b1;
      @(posedge clock_in);
      awaddr_in <= a;
      wdata_in <= v;
      awvalid_in <= 1'b1;
      wvalid_in <= 1'b1;
      bready_in <= 1'b1;
      while (pa || pw) begin
         @(posedge clock_in);
         if (pa && awready_out) begin
            awvalid_in <= 1'b0;
            pa = 1'b0;
         end
         if (pw && wready_out) begin
            wvalid_in <= 1'b0;
            pw = 1'b0;
         end
      end
      do @(posedge clock_in); while (bvalid_out !== 1'b1);
      rsp = bresp_out;
      bready_in <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a);
      logic pa = 1'b1;
      @(posedge clock_in);
      araddr_in <= a;
      arvalid_in <= 1'b1;
      rready_in <= 1'b1;
      do begin
         @(posedge clock_in);
         if (pa && arready_out) begin
            arvalid_in <= 1'b0;
            pa = 1'b0;
         end
      end while (rvalid_out !== 1'b1);
      d = rdata_out;
      rsp = rresp_out;
      rready_in <= 1'b0;
   endtask
   task automatic rc(input logic [11:0] a, input logic [31:0] x, string n);
      rd(a);
      `CHK(n, x, d)
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      repeat (30000) @(posedge clock_in);
      err_count++;
      results();
   end
   // ---------------------------------------------
   // tests
   // ---------------------------------------------
   initial begin
      repeat (12) @(posedge clock_in);
      sys_rst_in <= 1'b0;
      rc(OFF_ILR, ILR_RESET, "load");
      rc(OFF_VAL, CNT_RESET, "value");
      rc(12'h200, 32'h0, "unmapped");
      `CHK("rresp", RESP_SLVERR, rsp)
      wr(12'h200, 32'h1);
      `CHK("bresp", RESP_SLVERR, rsp)
      $display("reset test done");
      wr(OFF_CFG, 32'(CFG_16));
      wr(OFF_MODE, 32'h3);
      wr(OFF_CTL, 32'hD);
      wr(OFF_IMR, 32'h2);
      i_pin_partner.toggle(6);
      repeat (8) @(posedge clock_in);
      rc(OFF_RIS, 32'h0, "gated");
      wr(OFF_GATE, 32'h1);
      foreach (evq[i]) begin
         rnd = lfsr(rnd);
         k = 100 + rnd[5:0];
         wr(OFF_CTL, 32'h0);
         wr(OFF_ILR, 32'(k));
         wr(OFF_MATCH, 32'h0);
         wr(OFF_CTL, {28'h0, evq[i], 2'b01});
         i_pin_partner.toggle(4);
         repeat (8) @(posedge clock_in);
         rc(OFF_VAL, 32'(k - (evq[i] == EVT_BOTH ? 4 : 2)), "count");
      end
      wr(OFF_CTL, 32'h0);
      wr(OFF_ILR, 32'hA);
      wr(OFF_MATCH, 32'h6);
      wr(OFF_CTL, 32'hD);
      i_pin_partner.toggle(6);
      repeat (8) @(posedge clock_in);
      rc(OFF_MIS, 32'h2, "match");
      rc(OFF_CTL, 32'hC, "stopped");
      rc(OFF_VAL, 32'hA, "reload");
      wr(OFF_ICR, 32'h2);
      rc(OFF_RIS, 32'h0, "cleared");
      $display("edge count test done");
      wr(OFF_CTL, 32'h0);
      wr(OFF_MODE, 32'h7);
      wr(OFF_PRE, 32'h7);
      wr(OFF_ILR, 32'h64);
      wr(OFF_IMR, 32'h4);
      i_pin_partner.drive_out <= 1'b0;
      repeat (10) @(posedge clock_in);
      wr(OFF_CTL, 32'h1);
      fork
         i_pin_partner.rises(150);
         begin
            repeat (30) @(posedge clock_in);
            rd(OFF_VAL);
            c1 = d;
            repeat (40) @(posedge clock_in);
            rc(OFF_VAL, c1, "held");
         end
      join
      repeat (10) @(posedge clock_in);
      rc(OFF_VAL, 32'(wrapc(int'(c1), 150, 101)), "capture");
      rc(OFF_MIS, 32'h4, "event");
      $display("edge time test done");
      wr(OFF_CTL, 32'h0);
      wr(OFF_MODE, 32'hA);
      wr(OFF_ILR, 32'h9);
      wr(OFF_MATCH, 32'h3);
      wr(OFF_ICR, 32'hF);
      `CHK("oe", 1'b1, ccp_oe_out)
      for (k = 0; k < 2; k++) begin
         wr(OFF_CTL, 32'h0);
         wr(OFF_CTL, {25'h0, k[0], 6'h1});
         repeat (20) @(posedge clock_in);
         i_pin_partner.measure(100, hi);
         `CHK("duty", k ? 40 : 100 * (9 - 3) / 10, hi)
      end
      rc(OFF_RIS, 32'h0, "pwm flags");
      $display("pwm test done");
      wr(OFF_CTL, 32'h0);
      wr(OFF_CFG, 32'(CFG_32));
      wr(OFF_MODE, 32'(MR_ONESHOT));
      wr(OFF_ILR, 32'h1E);
      wr(OFF_IMR, 32'h1);
      wr(OFF_CTL, 32'h1);
      do rd(OFF_RIS); while (d[0] !== 1'b1);
      rc(OFF_MIS, 32'h1, "timeout");
      rc(OFF_CTL, 32'h0, "oneshot");
      wr(OFF_ICR, 32'h1);
      rc(OFF_RIS, 32'h0, "clear");
      wr(OFF_MODE, 32'(MR_PERIODIC));
      wr(OFF_CTL, 32'h1);
      do rd(OFF_RIS); while (d[0] !== 1'b1);
      wr(OFF_ICR, 32'h1);
      do rd(OFF_RIS); while (d[0] !== 1'b1);
      rc(OFF_CTL, 32'h1, "periodic");
      $display("timeout test done");
      wr(OFF_CTL, 32'h0);
      wr(OFF_CFG, 32'(CFG_16));
      wr(OFF_PRE, 32'h3);
      wr(OFF_ILR, 32'h100);
      wr(OFF_CTL, 32'h1);
      rd(OFF_VAL);
      c1 = d;
      repeat (37) @(posedge clock_in);
      // samples 40 edges apart: ten ticks of a divide-by-four prescaler
      rc(OFF_VAL, c1 - 32'hA, "prescale");
      wr(OFF_CTL, 32'h0);
      wr(OFF_CFG, 32'(CFG_RTC));
      wr(OFF_MATCH, 32'h2);
      wr(OFF_IMR, 32'h8);
      wr(OFF_CTL, 32'h1);
      // eight rises: two rtc ticks, count 1 to 2, then wrap at match
      i_pin_partner.toggle(16);
      repeat (8) @(posedge clock_in);
      rc(OFF_VAL, 32'h0, "rtc wrap");
      rc(OFF_MIS, 32'h8, "rtc flag");
      $display("prescale and rtc test done");
      results();
   end
endmodule
bind gp_timer_capture_pwm gp_timer_props i_gp_timer_props (
   .clock_in(clock_in), .sys_rst_in(sys_rst_in),
   .awvalid_in(awvalid_in), .awready_out(awready_out),
   .wvalid_in(wvalid_in), .wready_out(wready_out),
   .bvalid_out(bvalid_out), .bresp_out(bresp_out), .bready_in(bready_in),
   .araddr_in(araddr_in), .arvalid_in(arvalid_in),
   .arready_out(arready_out), .rdata_out(rdata_out),
   .rresp_out(rresp_out), .rvalid_out(rvalid_out), .rready_in(rready_in),
   .ccp_out(ccp_out), .ccp_oe_out(ccp_oe_out));
